// ---- common/dcf_regs.svh ----
// Named constants for the nine-bit buffer: geometry, reset values, register map and field positions.
// Assumes inclusion by bare name from any design file that needs them.
`ifndef DCF_REGS_SVH
`define DCF_REGS_SVH

`define DCF_WORD_W 9
`define DCF_DEPTH 64
`define DCF_PTR_W 6
`define DCF_CNT_W 7
`define DCF_DEPTH_CNT 7'h40
`define DCF_DEPTH_WIDE 17'h00040
`define DCF_CNT_ONE 7'h01
`define DCF_PTR_ONE 6'h01
`define DCF_CNT_ZERO 7'h00
`define DCF_PTR_ZERO 6'h00
`define DCF_OFS_W 8
`define DCF_OFS_DEFAULT_LSB 8'h07
`define DCF_OFS_DEFAULT_MSB 8'h00
`define DCF_WORD_ZERO 9'h000

`define DCF_AXI_ADDR_W 8
`define DCF_ADDR_CTRL 8'h00
`define DCF_ADDR_STATUS 8'h04
`define DCF_ADDR_OFFSETS 8'h08
`define DCF_ADDR_LEVEL 8'h0C
`define DCF_RESP_OKAY 2'h0
`define DCF_RESP_SLVERR 2'h2

`define DCF_CTRL_SOFT_RESET 0
`define DCF_STAT_EMPTY_N 0
`define DCF_STAT_FULL_N 1
`define DCF_STAT_AEMPTY_N 2
`define DCF_STAT_AFULL_N 3
`define DCF_STAT_MODE 4
`define DCF_STAT_WSEL_LO 8
`define DCF_STAT_RSEL_LO 12

`endif

// ---- common/dcf_pkg.sv ----
// Types shared by the buffer modules: strap mode, offset register selector and address decode.
// Assumes dcf_regs.svh is available on the include path.
`include "dcf_regs.svh"

package dcf_pkg;

	// Mode caught from the dual-purpose pin while reset is held.
	typedef enum logic {
		DCF_MODE_PROG = 1'b0,
		DCF_MODE_DUAL = 1'b1
	} dcf_mode_e;

	// Offset registers in their loading order.
	typedef enum logic [1:0] {
		DCF_OFS_EMPTY_LSB = 2'b00,
		DCF_OFS_EMPTY_MSB = 2'b01,
		DCF_OFS_FULL_LSB = 2'b10,
		DCF_OFS_FULL_MSB = 2'b11
	} dcf_ofs_e;

	// Rotating selector: after the last register loading wraps to the first.
	function automatic dcf_ofs_e dcf_ofs_step(input dcf_ofs_e sel);
		dcf_ofs_step = dcf_ofs_e'(sel + 2'b01);
	endfunction

	// True for the four mapped register words.
	function automatic logic dcf_addr_hit(input logic [`DCF_AXI_ADDR_W-1:0] addr);
		dcf_addr_hit = (addr == `DCF_ADDR_CTRL) || (addr == `DCF_ADDR_STATUS) ||
			(addr == `DCF_ADDR_OFFSETS) || (addr == `DCF_ADDR_LEVEL);
	endfunction

endpackage

// ---- hdl/dcf_mem.sv ----
// Flip-flop storage array of the buffer, one write port and one indexed read port.
// Assumes the caller only writes a free location and only reads an occupied one.
`timescale 1ns/1ps
`include "dcf_regs.svh"

module dcf_mem (
	input wire logic aclk, // System clock.
	input wire logic wr_en, // Store wr_word at wr_idx this edge.
	input wire logic [`DCF_PTR_W-1:0] wr_idx, // Write location.
	input wire logic [`DCF_WORD_W-1:0] wr_word, // Word to store.
	input wire logic [`DCF_PTR_W-1:0] rd_idx, // Read location.
	output logic [`DCF_WORD_W-1:0] rd_word // Word at rd_idx.
);

	logic [`DCF_WORD_W-1:0] store_reg [`DCF_DEPTH];
	logic [`DCF_WORD_W-1:0] store_next [`DCF_DEPTH];

	// Only the addressed word changes; storage needs no reset since reads are gated by the count.
	always_comb begin
		store_next = store_reg;
		if (wr_en) begin
			store_next[wr_idx] = wr_word;
		end
	end

	always_ff @(posedge aclk) begin
		store_reg <= store_next;
	end

	assign rd_word = store_reg[rd_idx];

endmodule

// ---- hdl/dcf_axil.sv ----
// AXI4-Lite slave that turns bus transfers into a write pulse and a read address for the register file.
// Assumes the register file returns read data combinationally from reg_rd_addr.
`timescale 1ns/1ps
`include "dcf_regs.svh"

module dcf_axil (
	input wire logic aclk, // System clock.
	input wire logic aresetn, // Synchronous reset, active low.
	input wire logic [`DCF_AXI_ADDR_W-1:0] s_axi_awaddr, // Write address.
	input wire logic s_axi_awvalid, // Write address valid.
	output logic s_axi_awready, // Write address ready.
	input wire logic [31:0] s_axi_wdata, // Write data.
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
	input wire logic s_axi_wvalid, // Write data valid.
	output logic s_axi_wready, // Write data ready.
	output logic [1:0] s_axi_bresp, // Write response.
	output logic s_axi_bvalid, // Write response valid.
	input wire logic s_axi_bready, // Write response ready.
	input wire logic [`DCF_AXI_ADDR_W-1:0] s_axi_araddr, // Read address.
	input wire logic s_axi_arvalid, // Read address valid.
	output logic s_axi_arready, // Read address ready.
	output logic [31:0] s_axi_rdata, // Read data.
	output logic [1:0] s_axi_rresp, // Read response.
	output logic s_axi_rvalid, // Read data valid.
	input wire logic s_axi_rready, // Read data ready.
	output logic reg_wr_en, // One-cycle register write pulse.
	output logic [`DCF_AXI_ADDR_W-1:0] reg_wr_addr, // Register write address.
	output logic [31:0] reg_wr_data, // Register write data.
	output logic [3:0] reg_wr_strb, // Register write strobes.
	output logic [`DCF_AXI_ADDR_W-1:0] reg_rd_addr, // Register read address.
	input wire logic [31:0] reg_rd_data // Register read data.
);

	logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
	logic [`DCF_AXI_ADDR_W-1:0] aw_addr_reg, aw_addr_next;
	logic [31:0] w_data_reg, w_data_next;
	logic [3:0] w_strb_reg, w_strb_next;
	logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;

	// Address and data are caught in either order; the write is committed once both are held.
	assign s_axi_awready = !aw_held_reg && !bvalid_reg;
	assign s_axi_wready = !w_held_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign reg_wr_en = aw_held_reg && w_held_reg && !bvalid_reg;
	assign reg_wr_addr = aw_addr_reg;
	assign reg_wr_data = w_data_reg;
	assign reg_wr_strb = w_strb_reg;
	assign reg_rd_addr = s_axi_araddr;

	// Next state of both channels; an unmapped word answers SLVERR and reads as zero.
	always_comb begin
		aw_held_next = aw_held_reg;
		aw_addr_next = aw_addr_reg;
		w_held_next = w_held_reg;
		w_data_next = w_data_reg;
		w_strb_next = w_strb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held_next = 1'b1;
			aw_addr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held_next = 1'b1;
			w_data_next = s_axi_wdata;
			w_strb_next = s_axi_wstrb;
		end
		if (reg_wr_en) begin
			aw_held_next = 1'b0;
			w_held_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = dcf_pkg::dcf_addr_hit(aw_addr_reg) ? `DCF_RESP_OKAY : `DCF_RESP_SLVERR;
		end else if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_next = 1'b1;
			rresp_next = dcf_pkg::dcf_addr_hit(s_axi_araddr) ? `DCF_RESP_OKAY : `DCF_RESP_SLVERR;
			rdata_next = dcf_pkg::dcf_addr_hit(s_axi_araddr) ? reg_rd_data : 32'h00000000;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= `DCF_ADDR_CTRL;
			w_held_reg <= 1'b0;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `DCF_RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg <= `DCF_RESP_OKAY;
			rdata_reg <= 32'h00000000;
		end else begin
			aw_held_reg <= aw_held_next;
			aw_addr_reg <= aw_addr_next;
			w_held_reg <= w_held_next;
			w_data_reg <= w_data_next;
			w_strb_reg <= w_strb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;

endmodule

// ---- hdl/dcf_top.sv ----
// Nine-bit first-in first-out buffer with programmable almost flags and an AXI4-Lite register window.
// Assumes producer and consumer logic run on aclk, so their enables need no synchroniser.
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "dcf_regs.svh"

module dcf_top (
	input wire logic aclk, // Shared write and read clock.
	input wire logic aresetn, // Synchronous reset, active low.
	input wire logic [`DCF_AXI_ADDR_W-1:0] s_axi_awaddr, // Write address.
	input wire logic [2:0] s_axi_awprot, // Write protection, unused.
	input wire logic s_axi_awvalid, // Write address valid.
	output logic s_axi_awready, // Write address ready.
	input wire logic [31:0] s_axi_wdata, // Write data.
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
	input wire logic s_axi_wvalid, // Write data valid.
	output logic s_axi_wready, // Write data ready.
	output logic [1:0] s_axi_bresp, // Write response.
	output logic s_axi_bvalid, // Write response valid.
	input wire logic s_axi_bready, // Write response ready.
	input wire logic [`DCF_AXI_ADDR_W-1:0] s_axi_araddr, // Read address.
	input wire logic [2:0] s_axi_arprot, // Read protection, unused.
	input wire logic s_axi_arvalid, // Read address valid.
	output logic s_axi_arready, // Read address ready.
	output logic [31:0] s_axi_rdata, // Read data.
	output logic [1:0] s_axi_rresp, // Read response.
	output logic s_axi_rvalid, // Read data valid.
	input wire logic s_axi_rready, // Read data ready.
	input wire logic reset_input_n, // Buffer reset, active low.
	input wire logic [`DCF_WORD_W-1:0] write_word_in, // Word to write.
	input wire logic primary_write_enable_n, // Primary write enable, active low.
	input wire logic second_enable_or_load, // Second enable or load control.
	input wire logic read_enable_a_n, // First read enable, active low.
	input wire logic read_enable_b_n, // Second read enable, active low.
	input wire logic output_enable_n, // Output enable, active low.
	output logic [`DCF_WORD_W-1:0] read_word_out, // Read data, registered.
	output logic read_word_oe_n, // Low while read_word_out drives.
	output logic empty_indicator_n, // Low when empty.
	output logic full_indicator_n, // Low when full.
	output logic almost_empty_indicator_n, // Low when almost empty.
	output logic almost_full_indicator_n // Low when almost full.
);

	logic reg_wr_en;
	logic [`DCF_AXI_ADDR_W-1:0] reg_wr_addr, reg_rd_addr;
	logic [31:0] reg_wr_data, reg_rd_data;
	logic [3:0] reg_wr_strb;
	logic [`DCF_WORD_W-1:0] mem_rd_word;
	logic fifo_rst, soft_rst_reg, soft_rst_next;
	dcf_pkg::dcf_mode_e mode_reg, mode_next;
	dcf_pkg::dcf_ofs_e wsel_reg, wsel_next, rsel_reg, rsel_next;
	logic [`DCF_OFS_W-1:0] ofs_reg [4];
	logic [`DCF_OFS_W-1:0] ofs_next [4];
	logic [`DCF_PTR_W-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
	logic [`DCF_CNT_W-1:0] count_reg, count_next;
	logic [`DCF_WORD_W-1:0] out_reg, out_next;
	logic empty_n_reg, empty_n_next, full_n_reg, full_n_next;
	logic aempty_n_reg, aempty_n_next, afull_n_reg, afull_n_next;
	logic offset_load_n, data_write_req, ofs_write, ofs_read, read_req, do_write, do_read;
	logic [15:0] empty_ofs, full_ofs;

	dcf_axil u_axil (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.reg_wr_en(reg_wr_en),
		.reg_wr_addr(reg_wr_addr),
		.reg_wr_data(reg_wr_data),
		.reg_wr_strb(reg_wr_strb),
		.reg_rd_addr(reg_rd_addr),
		.reg_rd_data(reg_rd_data)
	);

	// Storage is sized to the fixed variant, nine bits by sixty-four words.
	dcf_mem u_mem (
		.aclk(aclk),
		.wr_en(do_write),
		.wr_idx(wptr_reg),
		.wr_word(write_word_in),
		.rd_idx(rptr_reg),
		.rd_word(mem_rd_word)
	);

	// Any of the three resets empties the buffer; the soft one is a self-clearing pulse.
	assign fifo_rst = !aresetn || !reset_input_n || soft_rst_reg;
	assign empty_ofs = {ofs_reg[dcf_pkg::DCF_OFS_EMPTY_MSB], ofs_reg[dcf_pkg::DCF_OFS_EMPTY_LSB]};
	assign full_ofs = {ofs_reg[dcf_pkg::DCF_OFS_FULL_MSB], ofs_reg[dcf_pkg::DCF_OFS_FULL_LSB]};

	// Request decode. With one clock for both ports the read and write sides share aclk.
	assign offset_load_n = (mode_reg == dcf_pkg::DCF_MODE_PROG) ? second_enable_or_load : 1'b1;
	assign data_write_req = !primary_write_enable_n && second_enable_or_load;
	assign ofs_write = !offset_load_n && !primary_write_enable_n;
	assign read_req = !read_enable_a_n && !read_enable_b_n;
	assign ofs_read = !offset_load_n && read_req;
	assign do_write = data_write_req && full_n_reg && !fifo_rst;
	assign do_read = read_req && offset_load_n && empty_n_reg && !fifo_rst;

	// Pointer, count, flag and output state; flags follow the count they will describe.
	always_comb begin
		mode_next = mode_reg;
		wptr_next = wptr_reg + (do_write ? `DCF_PTR_ONE : `DCF_PTR_ZERO);
		rptr_next = rptr_reg + (do_read ? `DCF_PTR_ONE : `DCF_PTR_ZERO);
		count_next = count_reg + (do_write ? `DCF_CNT_ONE : `DCF_CNT_ZERO) - (do_read ? `DCF_CNT_ONE : `DCF_CNT_ZERO);
		out_next = out_reg;
		if (do_read) begin
			out_next = mem_rd_word;
		end else if (ofs_read) begin
			out_next = {1'b0, ofs_reg[rsel_reg]};
		end
		if (fifo_rst) begin
			mode_next = dcf_pkg::dcf_mode_e'(second_enable_or_load);
			wptr_next = `DCF_PTR_ZERO;
			rptr_next = `DCF_PTR_ZERO;
			count_next = `DCF_CNT_ZERO;
			out_next = `DCF_WORD_ZERO;
		end
		empty_n_next = (count_next != `DCF_CNT_ZERO);
		full_n_next = (count_next != `DCF_DEPTH_CNT);
		aempty_n_next = ({9'h000, count_next} > empty_ofs);
		afull_n_next = (({10'h000, count_next} + {1'b0, full_ofs}) < `DCF_DEPTH_WIDE);
	end

	always_ff @(posedge aclk) begin
		mode_reg <= mode_next;
		wptr_reg <= wptr_next;
		rptr_reg <= rptr_next;
		count_reg <= count_next;
		out_reg <= out_next;
		empty_n_reg <= empty_n_next;
		full_n_reg <= full_n_next;
		aempty_n_reg <= aempty_n_next;
		afull_n_reg <= afull_n_next;
	end

	// Offset registers: the pin load wins over a bus write to the same register in one cycle.
	always_comb begin
		ofs_next = ofs_reg;
		wsel_next = wsel_reg;
		rsel_next = rsel_reg;
		soft_rst_next = reg_wr_en && (reg_wr_addr == `DCF_ADDR_CTRL) && reg_wr_strb[0] &&
			reg_wr_data[`DCF_CTRL_SOFT_RESET];
		if (reg_wr_en && (reg_wr_addr == `DCF_ADDR_OFFSETS)) begin
			for (int i = 0; i < 4; i++) begin
				if (reg_wr_strb[i]) begin
					ofs_next[i] = reg_wr_data[i*8 +: 8];
				end
			end
		end
		if (ofs_write) begin
			ofs_next[wsel_reg] = write_word_in[`DCF_OFS_W-1:0];
			wsel_next = dcf_pkg::dcf_ofs_step(wsel_reg);
		end
		if (ofs_read) begin
			rsel_next = dcf_pkg::dcf_ofs_step(rsel_reg);
		end
		if (fifo_rst) begin
			ofs_next[dcf_pkg::DCF_OFS_EMPTY_LSB] = `DCF_OFS_DEFAULT_LSB;
			ofs_next[dcf_pkg::DCF_OFS_EMPTY_MSB] = `DCF_OFS_DEFAULT_MSB;
			ofs_next[dcf_pkg::DCF_OFS_FULL_LSB] = `DCF_OFS_DEFAULT_LSB;
			ofs_next[dcf_pkg::DCF_OFS_FULL_MSB] = `DCF_OFS_DEFAULT_MSB;
			wsel_next = dcf_pkg::DCF_OFS_EMPTY_LSB;
			rsel_next = dcf_pkg::DCF_OFS_EMPTY_LSB;
		end
		if (!aresetn) begin
			soft_rst_next = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		ofs_reg <= ofs_next;
		wsel_reg <= wsel_next;
		rsel_reg <= rsel_next;
		soft_rst_reg <= soft_rst_next;
	end

	// Register read mux; CTRL reads zero because its only bit is a pulse.
	always_comb begin
		reg_rd_data = 32'h00000000;
		unique case (reg_rd_addr)
			`DCF_ADDR_STATUS: begin
				reg_rd_data[`DCF_STAT_EMPTY_N] = empty_n_reg;
				reg_rd_data[`DCF_STAT_FULL_N] = full_n_reg;
				reg_rd_data[`DCF_STAT_AEMPTY_N] = aempty_n_reg;
				reg_rd_data[`DCF_STAT_AFULL_N] = afull_n_reg;
				reg_rd_data[`DCF_STAT_MODE] = mode_reg;
				reg_rd_data[`DCF_STAT_WSEL_LO +: 2] = wsel_reg;
				reg_rd_data[`DCF_STAT_RSEL_LO +: 2] = rsel_reg;
			end
			`DCF_ADDR_OFFSETS: reg_rd_data = {ofs_reg[3], ofs_reg[2], ofs_reg[1], ofs_reg[0]};
			`DCF_ADDR_LEVEL: reg_rd_data = {25'h0000000, count_reg};
			default: reg_rd_data = 32'h00000000;
		endcase
	end

	// Tri-state is resolved outside; the enable simply follows the pin.
	assign read_word_out = out_reg;
	assign read_word_oe_n = output_enable_n;
	assign empty_indicator_n = empty_n_reg;
	assign full_indicator_n = full_n_reg;
	assign almost_empty_indicator_n = aempty_n_reg;
	assign almost_full_indicator_n = afull_n_reg;

	default clocking dcf_cb @(posedge aclk);
	endclocking
	default disable iff (fifo_rst);

	property p_write_grows;
		(data_write_req && full_n_reg && !read_req) |=> (count_reg == $past(count_reg) + `DCF_CNT_ONE);
	endproperty
	a_write_grows: assert property (p_write_grows) else $error("Enabled write did not add a word.");

	property p_full_blocks;
		(!full_n_reg && !read_req) |=> (count_reg == $past(count_reg)) && (wptr_reg == $past(wptr_reg));
	endproperty
	a_full_blocks: assert property (p_full_blocks) else $error("Write taken while full.");

	property p_empty_exact;
		empty_indicator_n == (count_reg != `DCF_CNT_ZERO);
	endproperty
	a_empty_exact: assert property (p_empty_exact) else $error("Empty indicator disagrees with count.");

	property p_full_exact;
		full_indicator_n == (count_reg != `DCF_DEPTH_CNT);
	endproperty
	a_full_exact: assert property (p_full_exact) else $error("Full indicator disagrees with count.");

	property p_aempty_level;
		almost_empty_indicator_n == ({9'h000, count_reg} > $past(empty_ofs));
	endproperty
	a_aempty_level: assert property (p_aempty_level) else $error("Almost-empty wrong for level.");

	property p_ofs_rotate;
		ofs_write |=> (wsel_reg == dcf_pkg::dcf_ofs_step($past(wsel_reg))) &&
			(ofs_reg[$past(wsel_reg)] == $past(write_word_in[`DCF_OFS_W-1:0]));
	endproperty
	a_ofs_rotate: assert property (p_ofs_rotate) else $error("Offset load did not rotate.");

	property p_ofs_readback;
		ofs_read |=> (read_word_out == {1'b0, $past(ofs_reg[rsel_reg])});
	endproperty
	a_ofs_readback: assert property (p_ofs_readback) else $error("Offset read returned wrong value.");

	property p_empty_read_holds;
		(read_req && !empty_n_reg && offset_load_n) |=> $stable(read_word_out) && $stable(rptr_reg);
	endproperty
	a_empty_read_holds: assert property (p_empty_read_holds) else $error("Read from empty moved state.");

	property p_reset_clears;
		@(posedge aclk) disable iff (1'b0) fifo_rst |=> (count_reg == `DCF_CNT_ZERO) && !empty_indicator_n &&
			(ofs_reg[dcf_pkg::DCF_OFS_EMPTY_LSB] == `DCF_OFS_DEFAULT_LSB);
	endproperty
	a_reset_clears: assert property (p_reset_clears) else $error("Reset did not empty the buffer.");

endmodule

// ---- verif/dcf_peer.sv ----
// Pin-level peer of the buffer: producer on the write side and consumer on the read side.
// Assumes the bench sets its requests by non-blocking assignment right after a rising edge of aclk.
`timescale 1ns/1ps
`include "dcf_regs.svh"

module dcf_peer (
	input wire logic aclk, // Shared clock.
	input wire logic rq_wr, // Bench asks for a write this cycle.
	input wire logic rq_rd, // Bench asks for a read this cycle.
	input wire logic rq_load, // Bench holds the load function, also the mode strap.
	input wire logic [`DCF_WORD_W-1:0] rq_word, // Word to offer.
	output logic [`DCF_WORD_W-1:0] write_word_in, // Data pins.
	output logic primary_write_enable_n, // System write enable.
	output logic second_enable_or_load, // Expansion enable or load.
	output logic read_enable_a_n, // First read enable.
	output logic read_enable_b_n // Second read enable.
);
	logic [`DCF_WORD_W-1:0] last_reg = 9'h155;

	// Remember the last word driven, so that an idle data bus never repeats it.
	always_ff @(posedge aclk) begin
		if (rq_wr) begin
			last_reg <= write_word_in;
		end
	end

	// One enable acts as system control, the other as expansion control; the strap level holds through reset.
	always_comb begin
		primary_write_enable_n = !rq_wr;
		second_enable_or_load = !rq_load;
		read_enable_a_n = !rq_rd;
		read_enable_b_n = !rq_rd;
		write_word_in = rq_wr ? rq_word : ~last_reg; // Inverse of last value keeps stale data from matching by luck.
	end
endmodule

// ---- verif/test_dual_clock_sync_fifo_9bit.sv ----
// Self-checking bench for the nine-bit buffer: queue model, pin peer and AXI4-Lite master tasks.
// Assumes one clock for bus and both data sides, as the design provides.
`timescale 1ns/1ps
`include "dcf_regs.svh"

module test_dual_clock_sync_fifo_9bit;
	logic aclk = 1'b0, aresetn = 1'b0, reset_input_n = 1'b1, output_enable_n = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic rq_wr = 1'b0, rq_rd = 1'b0, rq_load = 1'b0, chk = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [8:0] rq_word = 9'h000, wwin, rwo, exp_q;
	logic awready, wready, bvalid, arready, rvalid, pwe_n, sel, rena, renb, oe_n, emp_n, ful_n, ae, af;
	logic [1:0] bresp, rresp, wsel, rsel;
	logic [8:0] q[$];
	logic [7:0] ofs[4];
	int seed = 99, n_fail = 0, checks_done = 0;

	dcf_peer u_dcf_peer (.aclk(aclk), .rq_wr(rq_wr), .rq_rd(rq_rd), .rq_load(rq_load), .rq_word(rq_word),
		.write_word_in(wwin), .primary_write_enable_n(pwe_n), .second_enable_or_load(sel),
		.read_enable_a_n(rena), .read_enable_b_n(renb));
	dcf_top u_dcf_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .reset_input_n(reset_input_n), .write_word_in(wwin),
		.primary_write_enable_n(pwe_n), .second_enable_or_load(sel), .read_enable_a_n(rena),
		.read_enable_b_n(renb), .output_enable_n(output_enable_n), .read_word_out(rwo),
		.read_word_oe_n(oe_n), .empty_indicator_n(emp_n), .full_indicator_n(ful_n),
		.almost_empty_indicator_n(ae), .almost_full_indicator_n(af));

	// Free-running 100 MHz clock.
	initial begin
		forever #5 aclk = ~aclk;
	end

	task conclude;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task mreset;
		q.delete();
		exp_q = 9'h000;
		ofs = '{8'h07, 8'h00, 8'h07, 8'h00};
		wsel = 2'h0;
		rsel = 2'h0;
	endtask

	// Reset through either pin; the load request doubles as the mode strap while reset is held.
	task rst(input bit pin, input bit mode);
		chk = 1'b0;
		if (pin) reset_input_n <= 1'b0;
		else aresetn <= 1'b0;
		rq_load <= mode;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		reset_input_n <= 1'b1;
		rq_load <= 1'b0;
		mreset();
		chk = 1'b1;
	endtask

	// One data cycle; the model follows the request at the edge that takes it.
	task cyc(input bit w, input bit r, input bit l);
		logic [8:0] d;
		int n;
		d = 9'($random(seed));
		if (l) d = wsel[0] ? 9'h000 : (d & 9'h01F); // Small offsets keep the flag sums in range.
		rq_wr <= w;
		rq_rd <= r;
		rq_load <= l;
		rq_word <= d;
		output_enable_n <= 1'($random(seed));
		@(posedge aclk);
		if (l) begin
			if (w) ofs[wsel] = d[7:0];
			if (w) wsel++;
			if (r) exp_q = {1'b0, ofs[rsel]};
			if (r) rsel++;
		end else begin
			n = q.size(); // Full and empty are judged on the level before this edge.
			if (r && n > 0) exp_q = q.pop_front();
			if (w && n < 64) q.push_back(d);
		end
	endtask

	task axw(input logic [7:0] a, input logic [31:0] d);
		int i;
		chk = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		bready <= 1'b0;
		if (i == 40) n_fail++;
		if (i == 40) conclude();
		cmp("bresp", `DCF_RESP_OKAY, bresp);
		@(posedge aclk);
	endtask

	task axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int i;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		rready <= 1'b0;
		if (i == 40) n_fail++;
		if (i == 40) conclude();
		cmp("rdata", ed, rdata);
		cmp("rresp", er, rresp);
		@(posedge aclk);
	endtask

	// Every cycle while chk is set the pins are held against the model, away from the edge.
	always @(negedge aclk) begin
		if (chk) begin
			cmp("read_word", exp_q, rwo);
			cmp("empty", q.size() != 0, emp_n);
			cmp("full", q.size() < 64, ful_n);
			cmp("almost_empty", q.size() > {ofs[1], ofs[0]}, ae);
			cmp("almost_full", q.size() + {ofs[3], ofs[2]} < 64, af);
			cmp("oe", output_enable_n, oe_n);
		end
	end

	initial begin
		rst(0, 0);
		repeat (2) cyc(0, 1, 0);
		cyc(0, 0, 0);
		axr(`DCF_ADDR_STATUS, 32'h0000001A, `DCF_RESP_OKAY);
		axr(8'h10, 32'h0, `DCF_RESP_SLVERR);
		$display("test empty done");
		repeat (66) cyc(1, 0, 0);
		cyc(1, 1, 0);
		cyc(0, 0, 0);
		axr(`DCF_ADDR_LEVEL, 32'd63, `DCF_RESP_OKAY);
		repeat (66) cyc(0, 1, 0);
		cyc(0, 0, 0);
		$display("test fill and drain done");
		axw(`DCF_ADDR_OFFSETS, 32'h00050003);
		ofs = '{8'h03, 8'h00, 8'h05, 8'h00};
		chk = 1'b1;
		axr(`DCF_ADDR_OFFSETS, 32'h00050003, `DCF_RESP_OKAY);
		repeat (300) cyc(1'($random(seed)), 1'($random(seed)), 0);
		cyc(0, 0, 0);
		axw(`DCF_ADDR_CTRL, 32'h1);
		mreset();
		chk = 1'b1;
		axr(`DCF_ADDR_LEVEL, 32'd0, `DCF_RESP_OKAY);
		$display("test random mix done");
		rst(1, 1);
		axr(`DCF_ADDR_STATUS, 32'h0000000A, `DCF_RESP_OKAY);
		repeat (5) cyc(1, 0, 1);
		cyc(0, 0, 0);
		repeat (4) cyc(0, 1, 1);
		cyc(0, 0, 0);
		repeat (40) cyc(1, 0, 0);
		repeat (41) cyc(0, 1, 0);
		cyc(0, 0, 0);
		$display("test offset mode done");
		conclude();
	end
endmodule
